/* File: rtl/vcgc_pkg.sv */
package vcgc_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_TRIM     = 8'he3;
    localparam logic [7:0] IDX_MCLK     = 8'he4;
    localparam logic [7:0] IDX_RDCTL    = 8'he5;
    localparam logic [7:0] IDX_CNTCTL   = 8'he6;
    localparam logic [7:0] IDX_DATA     = 8'he8;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hf0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;

    localparam logic [7:0] RST_TRIM     = 8'h00;
    localparam logic [7:0] RST_MCLK     = 8'h00;
    localparam logic [7:0] RST_RDCTL    = 8'h00;
    localparam logic [7:0] RST_CNTCTL   = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SLICER_LSB    = 2;
    localparam int EQ_GAIN_LSB   = 0;
    localparam int T1_RATE_LSB   = 6;
    localparam int E1_RATE_LSB   = 4;
    localparam int MON_SEL_BIT   = 7;
    localparam int RD_EN_BIT     = 6;
    localparam int CH_SEL_LSB    = 0;
    localparam int ALL_CLR_BIT   = 4;
    localparam int ALL_SNAP_BIT  = 3;
    localparam int BYTE_SEL_BIT  = 2;
    localparam int ONE_SNAP_BIT  = 1;
    localparam int ONE_CLR_BIT   = 0;

    // ------------------------------------------------------------------
    // decoded values
    // ------------------------------------------------------------------
    localparam logic [6:0]  SLICER_PCT_00 = 7'h32;
    localparam logic [6:0]  SLICER_PCT_01 = 7'h2d;
    localparam logic [6:0]  SLICER_PCT_10 = 7'h37;
    localparam logic [6:0]  SLICER_PCT_11 = 7'h44;
    localparam logic [1:0]  EQ_CUT_NONE   = 2'h0;
    localparam logic [1:0]  EQ_CUT_1DB    = 2'h1;
    localparam logic [1:0]  EQ_CUT_3DB    = 2'h3;
    localparam logic [14:0] T1_BASE_KHZ   = 15'h0608;
    localparam logic [14:0] E1_BASE_KHZ   = 15'h0800;
    localparam logic [3:0]  CH_NONE       = 4'h0;
    localparam logic [3:0]  CH_SPARE      = 4'hf;
    localparam logic [15:0] CNT_MAX       = 16'hffff;
    localparam logic [15:0] CNT_ZERO      = 16'h0000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint CORE_CLK_HZ    = 20000000;
    localparam longint CLEAR_HOLD_NS  = 1000;
    localparam int     CLEAR_HOLD_CYC =
        int'((CLEAR_HOLD_NS * CORE_CLK_HZ + 64'd999999999) / 64'd1000000000);

    typedef enum logic {APB_IDLE, APB_ANSWER} vcgc_apb_e;

    function automatic logic vcgc_ch_valid(input logic [3:0] code,
                                           input int         nch);
        return (code != CH_NONE) && (code != CH_SPARE) &&
               (int'(code) <= nch);
    endfunction

    function automatic logic [3:0] vcgc_ch_index(input logic [3:0] code);
        return code - 4'h1;
    endfunction

endpackage

/* File: rtl/vcgc_sat_counter.sv */
`timescale 1ns/1ps
module vcgc_sat_counter
    import vcgc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clr,
    input  wire logic             inc,
    output logic [WIDTH-1:0]      count,
    output logic                  full
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    assign full    = &count_q;
    // clear beats a violation in the same cycle
    assign count_d = clr ? '0 : ((inc && !full) ? count_q + 1'b1 : count_q);
    assign count   = count_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

/* File: rtl/vcgc_hold_mem.sv */
`timescale 1ns/1ps
module vcgc_hold_mem
    import vcgc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 14,
    parameter int AW    = 4
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [DEPTH-1:0]       wr_en,
    input  wire logic [DEPTH*WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]          rd_addr,
    output logic      [WIDTH-1:0]       rd_data
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    generate
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
            $error("DEPTH must lie in 1..2**AW");
        end
    endgenerate

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_word
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_q[i] <= '0;
                end else if (wr_en[i]) begin
                    mem_q[i] <= wr_data[i*WIDTH +: WIDTH];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else if (int'(rd_addr) < DEPTH) begin
            rd_data <= mem_q[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end

endmodule

/* File: rtl/vcgc_top.sv */
// Contract
// - slicer code sets 50/45/55/68 percent level
// - eq code 01 cuts 1dB, 10 cuts 3dB
// - t1 clock rate 1.544 doubling per code
// - e1 clock rate 2.048 doubling per code
// - monitor select routes violation or overflow
// - overflow asserted when counter saturates
// - counter holds ffff until a clear
// - read enable gates counter byte readback
// - select 0001..1110 picks channels 0..13
// - clock register spare bits are plain storage
// - clear bits zero counters, held one microsecond
// - all-snapshot copies every counter to holding
// - byte select picks low or high byte
// - data register shows chosen held byte
`timescale 1ns/1ps
module vcgc_top
    import vcgc_pkg::*;
#(
    parameter int NUM_CH = 14
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RESET,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic [NUM_CH-1:0] LINE_CODE_VIOLATION,
    output logic      [6:0]        SLICER_LEVEL_PCT,
    output logic      [1:0]        EQ_GAIN_CUT_DB,
    output logic      [14:0]       T1_MASTER_CLOCK_PIN_KHZ,
    output logic      [14:0]       E1_MASTER_CLOCK_PIN_KHZ,
    output logic      [NUM_CH-1:0] VIOLATION_MONITOR,
    output logic                   IRQ
);

    generate
        if (NUM_CH < 1 || NUM_CH > 14) begin : g_bad_num_ch
            $error("NUM_CH must lie in 1..14");
        end
    endgenerate

    localparam logic [7:0] CLR_HOLD_CNT = 8'(CLEAR_HOLD_CYC);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    vcgc_apb_e         state_q;
    logic [7:0]        trim_q;
    logic [7:0]        mclk_q;
    logic [7:0]        rdctl_q;
    logic [7:0]        cntctl_q;
    logic [NUM_CH-1:0] stat_q;
    logic [NUM_CH-1:0] mask_q;
    logic [31:0]       rd_word;
    logic [7:0]        data_byte;

    wire  [7:0] idx      = PADDR[9:2];
    wire        aligned  = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0);
    wire        hit_trim = aligned && (idx == IDX_TRIM);
    wire        hit_mclk = aligned && (idx == IDX_MCLK);
    wire        hit_rdc  = aligned && (idx == IDX_RDCTL);
    wire        hit_cntc = aligned && (idx == IDX_CNTCTL);
    wire        hit_data = aligned && (idx == IDX_DATA);
    wire        hit_stat = aligned && (idx == IDX_IRQ_STAT);
    wire        hit_mask = aligned && (idx == IDX_IRQ_MASK);
    wire        mapped   = hit_trim || hit_mclk || hit_rdc || hit_cntc ||
                           hit_data || hit_stat || hit_mask;
    wire        access   = PSEL && PENABLE;
    // writes land only at the edge where the master sees pready high
    wire        wr_fire  = (state_q == APB_ANSWER) && access && PWRITE &&
                           mapped;

    assign rd_word = hit_trim ? {24'h0, trim_q}   :
                     hit_mclk ? {24'h0, mclk_q}   :
                     hit_rdc  ? {24'h0, rdctl_q}  :
                     hit_cntc ? {24'h0, cntctl_q} :
                     hit_data ? {24'h0, data_byte} :
                     hit_stat ? {{(32-NUM_CH){1'b0}}, stat_q} :
                     hit_mask ? {{(32-NUM_CH){1'b0}}, mask_q} : 32'h0;

    // one wait state so that read data leave a flip-flop
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            state_q <= APB_IDLE;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end else begin
            case (state_q)
                APB_IDLE: begin
                    if (access) begin
                        state_q <= APB_ANSWER;
                        PREADY  <= 1'b1;
                        PSLVERR <= !mapped;
                        PRDATA  <= (!PWRITE && mapped) ? rd_word : 32'h0;
                    end
                end
                APB_ANSWER: begin
                    state_q <= APB_IDLE;
                    PREADY  <= 1'b0;
                    PSLVERR <= 1'b0;
                end
                default: state_q <= APB_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            trim_q   <= RST_TRIM;
            mclk_q   <= RST_MCLK;
            rdctl_q  <= RST_RDCTL;
            cntctl_q <= RST_CNTCTL;
        end else if (wr_fire) begin
            if (hit_trim) trim_q <= PWDATA[7:0];
            if (hit_mclk) mclk_q <= PWDATA[7:0];
            if (hit_rdc)  rdctl_q <= PWDATA[7:0];
            if (hit_cntc) cntctl_q <= PWDATA[7:0];
        end
    end

    wire [1:0] slicer_code = trim_q[SLICER_LSB +: 2];
    wire [1:0] eq_code     = trim_q[EQ_GAIN_LSB +: 2];
    wire [1:0] t1_code     = mclk_q[T1_RATE_LSB +: 2];
    wire [1:0] e1_code     = mclk_q[E1_RATE_LSB +: 2];
    wire       mon_sel     = rdctl_q[MON_SEL_BIT];
    wire       rd_en       = rdctl_q[RD_EN_BIT];
    wire [3:0] ch_sel      = rdctl_q[CH_SEL_LSB +: 4];
    wire       all_clr     = cntctl_q[ALL_CLR_BIT];
    wire       all_snap    = cntctl_q[ALL_SNAP_BIT];
    wire       byte_sel    = cntctl_q[BYTE_SEL_BIT];
    wire       one_snap    = cntctl_q[ONE_SNAP_BIT];
    wire       one_clr     = cntctl_q[ONE_CLR_BIT];

    wire       ch_ok  = vcgc_ch_valid(ch_sel, NUM_CH);
    wire [3:0] ch_idx = vcgc_ch_index(ch_sel);

    wire [6:0] slicer_pct = (slicer_code == 2'h0) ? SLICER_PCT_00 :
                            (slicer_code == 2'h1) ? SLICER_PCT_01 :
                            (slicer_code == 2'h2) ? SLICER_PCT_10 :
                                                    SLICER_PCT_11;
    wire [1:0] eq_cut = (eq_code == 2'h1) ? EQ_CUT_1DB :
                        (eq_code == 2'h2) ? EQ_CUT_3DB : EQ_CUT_NONE;

    // ------------------------------------------------------------------
    // counters, clear and snapshot
    // ------------------------------------------------------------------
    logic [7:0]        clr_cnt_q;
    logic              all_snap_q;
    logic              one_snap_q;
    logic [NUM_CH-1:0] viol_q;
    logic [NUM_CH-1:0] full;
    logic [NUM_CH-1:0] full_q;
    logic [NUM_CH-1:0] cnt_clr;
    logic [NUM_CH-1:0] snap_en;
    logic [NUM_CH*16-1:0] cnt_flat;
    logic [15:0]       hold_rd;

    // a clear only acts after the bit has stood for the full hold time
    wire clr_armed     = (clr_cnt_q == CLR_HOLD_CNT);
    wire all_snap_rise = all_snap && !all_snap_q;
    wire one_snap_rise = one_snap && !one_snap_q;

    always_ff @(posedge CORE_CLK) begin
        if (RESET || !(all_clr || one_clr)) begin
            clr_cnt_q <= 8'h00;
        end else if (!clr_armed) begin
            clr_cnt_q <= clr_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            all_snap_q <= 1'b0;
            one_snap_q <= 1'b0;
            viol_q     <= '0;
            full_q     <= '0;
        end else begin
            all_snap_q <= all_snap;
            one_snap_q <= one_snap;
            viol_q     <= LINE_CODE_VIOLATION;
            full_q     <= full;
        end
    end

    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
            wire pick = ch_ok && (ch_idx == 4'(i));
            assign cnt_clr[i] = clr_armed &&
                                (all_clr || (one_clr && pick));
            assign snap_en[i] = all_snap_rise ||
                                (one_snap_rise && pick);
            vcgc_sat_counter #(
                .WIDTH (16)
            ) u_cnt (
                .clk   (CORE_CLK),
                .rst   (RESET),
                .clr   (cnt_clr[i]),
                .inc   (LINE_CODE_VIOLATION[i]),
                .count (cnt_flat[i*16 +: 16]),
                .full  (full[i])
            );
        end
    endgenerate

    vcgc_hold_mem #(
        .WIDTH (16),
        .DEPTH (NUM_CH),
        .AW    (4)
    ) u_hold (
        .clk     (CORE_CLK),
        .rst     (RESET),
        .wr_en   (snap_en),
        .wr_data (cnt_flat),
        .rd_addr (ch_idx),
        .rd_data (hold_rd)
    );

    // readback stays dark unless enabled and a real channel is chosen
    assign data_byte = (rd_en && ch_ok) ?
                       (byte_sel ? hold_rd[15:8] : hold_rd[7:0]) :
                       8'h00;

    // ------------------------------------------------------------------
    // interrupts and pin outputs
    // ------------------------------------------------------------------
    wire [NUM_CH-1:0] ovf_rise = full & ~full_q;
    wire [NUM_CH-1:0] stat_w1c = (wr_fire && hit_stat) ?
                                 PWDATA[NUM_CH-1:0] : '0;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            stat_q <= '0;
            mask_q <= '0;
            IRQ    <= 1'b0;
        end else begin
            // a new overflow wins over a clear in the same cycle
            stat_q <= (stat_q & ~stat_w1c) | ovf_rise;
            if (wr_fire && hit_mask) mask_q <= PWDATA[NUM_CH-1:0];
            IRQ <= |(stat_q & mask_q);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            SLICER_LEVEL_PCT        <= SLICER_PCT_00;
            EQ_GAIN_CUT_DB          <= EQ_CUT_NONE;
            T1_MASTER_CLOCK_PIN_KHZ <= T1_BASE_KHZ;
            E1_MASTER_CLOCK_PIN_KHZ <= E1_BASE_KHZ;
            VIOLATION_MONITOR       <= '0;
        end else begin
            SLICER_LEVEL_PCT        <= slicer_pct;
            EQ_GAIN_CUT_DB          <= eq_cut;
            T1_MASTER_CLOCK_PIN_KHZ <= T1_BASE_KHZ << t1_code;
            E1_MASTER_CLOCK_PIN_KHZ <= E1_BASE_KHZ << e1_code;
            VIOLATION_MONITOR       <= mon_sel ? full : viol_q;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_clear_held;
        (all_clr && clr_armed);
    endsequence

    property p_slicer;
        @(posedge CORE_CLK) disable iff (RESET)
        (slicer_code == 2'h3) |=> (SLICER_LEVEL_PCT == 7'h44);
    endproperty
    a_slicer: assert property (p_slicer)
        else $error("slicer level not 68 percent");

    property p_eq;
        @(posedge CORE_CLK) disable iff (RESET)
        (eq_code == 2'h2) |=> (EQ_GAIN_CUT_DB == 2'h3);
    endproperty
    a_eq: assert property (p_eq)
        else $error("eq cut not 3dB");

    property p_t1;
        @(posedge CORE_CLK) disable iff (RESET)
        (t1_code == 2'h3) |=> (T1_MASTER_CLOCK_PIN_KHZ == 15'h3040);
    endproperty
    a_t1: assert property (p_t1)
        else $error("t1 clock not 12352 kHz");

    property p_e1;
        @(posedge CORE_CLK) disable iff (RESET)
        (e1_code == 2'h1) |=> (E1_MASTER_CLOCK_PIN_KHZ == 15'h1000);
    endproperty
    a_e1: assert property (p_e1)
        else $error("e1 clock not 4096 kHz");

    property p_monitor;
        @(posedge CORE_CLK) disable iff (RESET)
        (mon_sel && full[0]) |=> VIOLATION_MONITOR[0];
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("overflow not routed to monitor");

    property p_ovf_irq;
        @(posedge CORE_CLK) disable iff (RESET)
        (ovf_rise[0] && mask_q[0]) |=> stat_q[0] ##1 IRQ;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow did not raise interrupt");

    property p_saturate;
        @(posedge CORE_CLK) disable iff (RESET)
        (full[0] && !cnt_clr[0]) |=> (cnt_flat[15:0] == CNT_MAX);
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("counter left full scale without clear");

    property p_rd_gate;
        @(posedge CORE_CLK) disable iff (RESET)
        (!rd_en || ch_sel == CH_SPARE || ch_sel == CH_NONE)
            |-> (data_byte == 8'h00);
    endproperty
    a_rd_gate: assert property (p_rd_gate)
        else $error("readback visible while disabled");

    property p_byte;
        @(posedge CORE_CLK) disable iff (RESET)
        (rd_en && ch_ok && byte_sel) |-> (data_byte == hold_rd[15:8]);
    endproperty
    a_byte: assert property (p_byte)
        else $error("high byte not presented");

    property p_clear;
        @(posedge CORE_CLK) disable iff (RESET)
        s_clear_held |=> (cnt_flat[15:0] == CNT_ZERO);
    endproperty
    a_clear: assert property (p_clear)
        else $error("held clear did not zero counter");

    property p_snap_all;
        @(posedge CORE_CLK) disable iff (RESET)
        all_snap_rise |-> (&snap_en);
    endproperty
    a_snap_all: assert property (p_snap_all)
        else $error("snapshot missed a channel");

    property p_snap_one;
        @(posedge CORE_CLK) disable iff (RESET)
        (one_snap_rise && !all_snap_rise && ch_ok)
            |-> (snap_en == (NUM_CH'(1) << ch_idx));
    endproperty
    a_snap_one: assert property (p_snap_one)
        else $error("channel snapshot targeted wrong word");

    property p_count;
        @(posedge CORE_CLK) disable iff (RESET)
        (LINE_CODE_VIOLATION[0] && !full[0] && !cnt_clr[0])
            |=> (cnt_flat[15:0] == $past(cnt_flat[15:0]) + 16'h0001);
    endproperty
    a_count: assert property (p_count)
        else $error("violation not counted");

endmodule

/* File: tb/vcgc_apb_host.sv */
`timescale 1ns/1ps
module vcgc_apb_host (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // ----------------------------------------------------------------
    // one transfer, held steady until pready is seen at an edge
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

/* File: tb/violation_counter_global_config_tb.sv */
`timescale 1ns/1ps
module violation_counter_global_config_tb;
    import vcgc_pkg::*;
    localparam int NCH = 14;
    logic        core_clk, reset, psel, penable, pwrite;
    logic        pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NCH-1:0] line_code_violation, mon;
    logic [6:0]  slicer;
    logic [1:0]  eq;
    logic [14:0] t1k, e1k;
    int          bad_count, n_compared, cyc, sel;
    int          cnt[NCH], held[NCH];
    int          pct[4] = '{50, 45, 55, 68};
    int          cut[4] = '{0, 1, 3, 0};

    vcgc_top #(.NUM_CH(NCH)) i_vcgc_top (
        .CORE_CLK(core_clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LINE_CODE_VIOLATION(line_code_violation),
        .SLICER_LEVEL_PCT(slicer), .EQ_GAIN_CUT_DB(eq),
        .T1_MASTER_CLOCK_PIN_KHZ(t1k), .E1_MASTER_CLOCK_PIN_KHZ(e1k),
        .VIOLATION_MONITOR(mon), .IRQ(irq));
    vcgc_apb_host i_vcgc_apb_host (
        .clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    // whole run is about 67k cycles, mostly the saturation fill
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 75000) begin
            bad_count++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_vcgc_apb_host.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        i_vcgc_apb_host.xfer(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
    endtask
    task automatic selc(input int c);
        sel = c;
        wr(12'h394, 32'(8'h40 | c));
    endtask
    function automatic logic [31:0] eb(input int c, input int h);
        if (c < 1 || c > NCH)
            return 32'h0;
        return 32'((held[c-1] >> (8 * h)) & 255);
    endfunction
    task automatic snap(input int m);
        wr(12'h398, 32'(m));
        wr(12'h398, 32'h0);
        if (m == 8) held = cnt;
        if (m == 2 && sel >= 1 && sel <= NCH) held[sel-1] = cnt[sel-1];
    endtask
    task automatic clr(input int m);
        wr(12'h398, 32'(m));
        repeat (25) @(posedge core_clk);
        wr(12'h398, 32'h0);
        for (int i = 0; i < NCH; i++)
            if (m == 16 || (i + 1 == sel)) cnt[i] = 0;
    endtask
    task automatic read_all();
        for (int c = 0; c < 16; c++) begin
            selc(c);
            for (int h = 0; h < 2; h++) begin
                wr(12'h398, 32'(h * 4));
                rchk(12'h3a0, eb(c, h));
            end
        end
        $display("test readback sweep done");
    endtask
    task automatic burst(input int n);
        logic [NCH-1:0] v, p1, p2;
        p1 = '0;
        p2 = '0;
        for (int k = 0; k < n; k++) begin
            v = NCH'($urandom);
            line_code_violation <= v;
            for (int i = 0; i < NCH; i++) cnt[i] += v[i];
            @(posedge core_clk);
            // the monitor pin trails the violation input by two edges
            check(32'(mon), 32'(p2));
            p2 = p1;
            p1 = v;
        end
        line_code_violation <= '0;
        @(posedge core_clk);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] v;
        reset = 1'b1;
        line_code_violation = '0;
        void'($urandom(32'h1e7b));
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rchk(12'h38c, 32'h0);
        rchk(12'h390, 32'h0);
        rchk(12'h394, 32'h0);
        check(32'(slicer), 32'd50);
        check(32'(eq), 32'h0);
        check(32'(t1k), 32'd1544);
        check(32'(e1k), 32'd2048);
        check(32'(mon), 32'h0);
        $display("test reset values done");
        for (int c = 0; c < 4; c++) begin
            wr(12'h38c, 32'(c * 4 + 3 - c));
            repeat (2) @(posedge core_clk);
            check(32'(slicer), 32'(pct[c]));
            check(32'(eq), 32'(cut[3-c]));
            v = {2'(c), 2'(3 - c), 4'($urandom)};
            wr(12'h390, 32'(v));
            repeat (2) @(posedge core_clk);
            check(32'(t1k), 32'(1544 << c));
            check(32'(e1k), 32'(2048 << (3 - c)));
            rchk(12'h390, 32'(v));
        end
        i_vcgc_apb_host.xfer(1'b0, 12'h39c, 32'h0, rd, err);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        $display("test trim and clock codes done");
        selc(0);
        burst(40);
        snap(8);
        read_all();
        wr(12'h394, 32'h01);
        rchk(12'h3a0, 32'h0);
        selc(15);
        clr(1);
        selc(3);
        clr(1);
        // hold the cleared word so the sweep below shows the clear
        snap(2);
        burst(20);
        selc(6);
        snap(2);
        read_all();
        clr(16);
        snap(8);
        read_all();
        wr(12'h3c4, 32'h3fff);
        wr(12'h394, 32'hc0);
        line_code_violation <= '1;
        repeat (65540) @(posedge core_clk);
        line_code_violation <= '0;
        foreach (cnt[i]) cnt[i] = 65535;
        check(32'(mon), 32'h3fff);
        check(32'(irq), 32'h1);
        rchk(12'h3c0, 32'h3fff);
        wr(12'h3c4, 32'h0);
        repeat (2) @(posedge core_clk);
        check(32'(irq), 32'h0);
        wr(12'h3c0, 32'h3fff);
        rchk(12'h3c0, 32'h0);
        $display("test saturation and interrupt done");
        snap(8);
        read_all();
        finish_test();
    end
endmodule
